// *** pkg/port_mux_regs.vh ***
// constants for the 8-bit port function mux
// assumes a single system clock and synchronous active-high reset
//
// Function
// - pin output enable follows the direction bit only, never the peripheral
// - bit 0 input feeds timer external clock; peripheral output is ground
// - bit 1 drives compare out zero; input feeds capture zero alt A
// - bit 2 drives compare out one; input feeds capture one alt A
// - bit 3 drives compare out two; input feeds capture two alt A
// - bit 4 drives subsystem peripheral clock; input feeds nothing
// - bit 5 drives compare out zero; input feeds nothing
// - bit 6 drives compare out one; input feeds nothing
// - bit 7 drives compare out two; input feeds nothing
// - each bit has output, input, irq enable, flag, edge select bits
`ifndef PORT_MUX_REGS_VH
`define PORT_MUX_REGS_VH

// ==========================================
// widths and reset values
`define PORT_WIDTH       8
`define PORT_RST_VAL     8'h00
`define PORT_OE_OFF      8'hFF
`define EDGE_RISE        1'b0
`define EDGE_FALL        1'b1

// ==========================================
// peripheral output source codes, 2 bits each, plus the bit index of the clock pin
`define SRC_GND          2'h0
`define SRC_CMP0         2'h1
`define SRC_CMP1         2'h2
`define SRC_CMP2         2'h3
`define SRC_SUBSYSTEM_PERIPHERAL_CLOCK_BIT    4

`endif

// *** src/pin_sync.v ***
// two-flop synchroniser plus previous-level register for edge detection
// assumes pins are sampled on clk_i with enable ce_i
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 8
) (
  input  wire         clk_i,
  input  wire         sys_rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] pin_i,
  output wire [W-1:0] level_o,
  output wire [W-1:0] prev_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  reg [W-1:0] prev_r;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
      prev_r <= {W{1'b0}};
    end else if (ce_i) begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign prev_o  = prev_r;
endmodule // pin_sync

// *** src/pin_irq_bit.v ***
// one port bit's interrupt flag with selectable edge
// assumes synchronised level and previous level inputs
`timescale 1ns/1ps
`include "port_mux_regs.vh"
module pin_irq_bit (
  input  wire clk_i,
  input  wire sys_rst_i,
  input  wire ce_i,
  input  wire level_i,
  input  wire prev_i,
  input  wire edge_sel_i,
  input  wire flag_clr_i,
  input  wire flag_set_i,
  output wire flag_o
);
  reg  flag_r;
  wire hit;

  assign hit = (edge_sel_i == `EDGE_FALL) ? (prev_i & ~level_i) : (~prev_i & level_i);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_r <= 1'b0;
    end else if (ce_i) begin
      // set wins over clear so a same-cycle edge is kept
      if (hit | flag_set_i) begin
        flag_r <= 1'b1;
      end else if (flag_clr_i) begin
        flag_r <= 1'b0;
      end
    end
  end

  assign flag_o = flag_r;
endmodule // pin_irq_bit

// *** src/port_function_mux.v ***
// 8-bit port: per-bit function mux, direction, input sync, edge interrupts
// assumes control bits come from a cpu register file as plain levels;
// timer and clock signals are synchronous to clk_i
`timescale 1ns/1ps
`include "port_mux_regs.vh"
module port_function_mux #(
  parameter W = `PORT_WIDTH
) (
  input  wire         clk_i,
  input  wire         sys_rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] pin_function_select_i,
  input  wire [W-1:0] pin_direction_bit_i,
  input  wire [W-1:0] pin_output_bit_i,
  input  wire [W-1:0] pin_irq_enable_i,
  input  wire [W-1:0] pin_irq_edge_select_i,
  input  wire [W-1:0] pin_irq_flag_clr_i,
  input  wire [W-1:0] pin_irq_flag_set_i,
  input  wire         timer_compare_out_zero_i,
  input  wire         timer_compare_out_one_i,
  input  wire         timer_compare_out_two_i,
  input  wire         subsystem_peripheral_clock_i,
  input  wire [W-1:0] pad_in_i,
  output wire [W-1:0] pad_out_o,
  output wire [W-1:0] pad_oe_n_o,
  output wire [W-1:0] pin_input_bit_o,
  output wire [W-1:0] pin_irq_flag_o,
  output wire         port_irq_o,
  output wire         timer_external_clock_in_o,
  output wire         timer_capture_in_zero_alt_a_o,
  output wire         timer_capture_in_one_alt_a_o,
  output wire         timer_capture_in_two_alt_a_o
);

  // ==========================================
  // peripheral source per bit
  function [1:0] bit_source;
    input integer idx;
    begin
      case (idx % 4)
        0:       bit_source = `SRC_GND;
        1:       bit_source = `SRC_CMP0;
        2:       bit_source = `SRC_CMP1;
        default: bit_source = `SRC_CMP2;
      endcase
    end
  endfunction

  // ==========================================
  // which pins hand their input on to the timer
  // spelled out bit by bit so a new pin map only edits this table
  function bit_feeds_timer;
    input integer idx;
    begin
      if (idx == 0) begin
        bit_feeds_timer = 1'b1;
      end else if (idx == 1) begin
        bit_feeds_timer = 1'b1;
      end else if (idx == 2) begin
        bit_feeds_timer = 1'b1;
      end else if (idx == 3) begin
        bit_feeds_timer = 1'b1;
      end else if (idx == 4) begin
        bit_feeds_timer = 1'b0;
      end else if (idx == 5) begin
        bit_feeds_timer = 1'b0;
      end else if (idx == 6) begin
        bit_feeds_timer = 1'b0;
      end else if (idx == 7) begin
        bit_feeds_timer = 1'b0;
      end else begin
        bit_feeds_timer = 1'b0;
      end
    end
  endfunction

  wire [W-1:0] level;
  wire [W-1:0] prev;
  wire [W-1:0] periph_out;
  wire [W-1:0] drive_mux;
  wire [W-1:0] tmr_route;
  wire [W-1:0] irq_hit;
  reg  [W-1:0] pad_out_r;
  reg  [W-1:0] pad_oe_n_r;
  reg  [W-1:0] pad_out_nxt;
  reg  [W-1:0] pad_oe_n_nxt;
  reg  [3:0]   tmr_in_r;
  reg  [3:0]   tmr_in_nxt;
  reg          irq_r;

  // ==========================================
  // input synchroniser
  pin_sync #(
    .W (W)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .pin_i     (pad_in_i),
    .level_o   (level),
    .prev_o    (prev)
  );

  assign pin_input_bit_o = level;

  // ==========================================
  // per-bit peripheral selection and flags
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      if (g == `SRC_SUBSYSTEM_PERIPHERAL_CLOCK_BIT) begin : g_clk
        assign periph_out[g] = subsystem_peripheral_clock_i;
      end else if (bit_source(g) == `SRC_CMP0) begin : g_c0
        assign periph_out[g] = timer_compare_out_zero_i;
      end else if (bit_source(g) == `SRC_CMP1) begin : g_c1
        assign periph_out[g] = timer_compare_out_one_i;
      end else if (bit_source(g) == `SRC_CMP2) begin : g_c2
        assign periph_out[g] = timer_compare_out_two_i;
      end else begin : g_gnd
        assign periph_out[g] = 1'b0;
      end

      pin_irq_bit u_irq (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .level_i    (level[g]),
        .prev_i     (prev[g]),
        .edge_sel_i (pin_irq_edge_select_i[g]),
        .flag_clr_i (pin_irq_flag_clr_i[g]),
        .flag_set_i (pin_irq_flag_set_i[g]),
        .flag_o     (pin_irq_flag_o[g])
      );
    end
  endgenerate

  // ==========================================
  // pad drive and timer input routing
  generate
    for (g = 0; g < W; g = g + 1) begin : g_route
      assign drive_mux[g] = pin_function_select_i[g] ? periph_out[g] : pin_output_bit_i[g];

      if (bit_feeds_timer(g)) begin : g_tmr
        assign tmr_route[g] = level[g] & pin_function_select_i[g];
      end else begin : g_none
        assign tmr_route[g] = 1'b0;
      end

      assign irq_hit[g] = pin_irq_flag_o[g] & pin_irq_enable_i[g];
    end
  endgenerate

  always @* begin
    pad_out_nxt  = drive_mux;
    pad_oe_n_nxt = ~pin_direction_bit_i;
    // gated by select so an idle timer input stays low
    tmr_in_nxt   = tmr_route[3:0];
  end

  // ==========================================
  // pad value register
  // registered outputs trade one cycle of latency for glitch-free pads
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pad_out_r <= `PORT_RST_VAL;
    end else if (ce_i) begin
      pad_out_r <= pad_out_nxt;
    end
  end

  // ==========================================
  // pad enable register
  // all pads released at reset so nothing fights the board
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pad_oe_n_r <= `PORT_OE_OFF;
    end else if (ce_i) begin
      pad_oe_n_r <= pad_oe_n_nxt;
    end
  end

  // ==========================================
  // timer input register
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      tmr_in_r <= 4'h0;
    end else if (ce_i) begin
      tmr_in_r <= tmr_in_nxt;
    end
  end

  // ==========================================
  // interrupt request register
  // one cycle behind the flags; cheaper than a wide or-tree on the pin
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= |irq_hit;
    end
  end

  // ==========================================
  // outputs
  assign pad_out_o                     = pad_out_r;
  assign pad_oe_n_o                    = pad_oe_n_r;
  assign port_irq_o                    = irq_r;
  assign timer_external_clock_in_o     = tmr_in_r[0];
  assign timer_capture_in_zero_alt_a_o = tmr_in_r[1];
  assign timer_capture_in_one_alt_a_o  = tmr_in_r[2];
  assign timer_capture_in_two_alt_a_o  = tmr_in_r[3];

endmodule // port_function_mux

// *** verif/mux_props.sv ***
// assertions for the port function mux, bound to its top
// assumes ce_i and sys_rst_i act on the clk_i rising edge
`timescale 1ns/1ps
module mux_props (
  input wire       clk_i,
  input wire       sys_rst_i,
  input wire       ce_i,
  input wire [7:0] pin_function_select_i,
  input wire [7:0] pin_direction_bit_i,
  input wire [7:0] pin_output_bit_i,
  input wire [7:0] pin_irq_enable_i,
  input wire       timer_compare_out_zero_i,
  input wire       timer_compare_out_one_i,
  input wire       timer_compare_out_two_i,
  input wire       subsystem_peripheral_clock_i,
  input wire [7:0] pad_in_i,
  input wire [7:0] pad_out_o,
  input wire [7:0] pad_oe_n_o,
  input wire [7:0] pin_input_bit_o,
  input wire [7:0] pin_irq_flag_o,
  input wire       port_irq_o,
  input wire       timer_external_clock_in_o,
  input wire       timer_capture_in_zero_alt_a_o,
  input wire       timer_capture_in_one_alt_a_o,
  input wire       timer_capture_in_two_alt_a_o
);
  reg       v_r;
  reg [7:0] s_r, o_r, d_r, p_r;
  // ==========================
  // last edge's inputs; v_r marks an edge that advanced state
  always @(posedge clk_i) begin
    v_r <= !sys_rst_i && ce_i;
    s_r <= pin_function_select_i;
    o_r <= pin_output_bit_i;
    d_r <= pin_direction_bit_i;
    p_r <= {timer_compare_out_two_i, timer_compare_out_one_i, timer_compare_out_zero_i,
            subsystem_peripheral_clock_i, timer_compare_out_two_i,
            timer_compare_out_one_i, timer_compare_out_zero_i, 1'b0};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_oe_dir: assert property (v_r |-> pad_oe_n_o == ~d_r) else $error("oe bad");
  a_bit0_gnd: assert property (v_r && s_r[0] |-> !pad_out_o[0]) else $error("b0 bad");
  a_cmp_low: assert property (v_r |-> ((pad_out_o ^ p_r) & s_r & 8'h0E) == 8'h00)
    else $error("low cmp bad");
  a_clk_drive: assert property (v_r && s_r[4] |-> pad_out_o[4] == p_r[4])
    else $error("clk pin bad");
  a_cmp_high: assert property (v_r |-> ((pad_out_o ^ p_r) & s_r & 8'hE0) == 8'h00)
    else $error("high cmp bad");
  a_port_out: assert property (v_r |-> ((pad_out_o ^ o_r) & ~s_r) == 8'h00)
    else $error("port out bad");
  a_in_sync: assert property (v_r && $past(v_r) |-> pin_input_bit_o == $past(pad_in_i, 2))
    else $error("sync bad");
  a_cap_route: assert property (v_r |-> {timer_capture_in_two_alt_a_o,
    timer_capture_in_one_alt_a_o, timer_capture_in_zero_alt_a_o, timer_external_clock_in_o}
    == ($past(pin_input_bit_o[3:0]) & s_r[3:0])) else $error("capture bad");
  a_irq_level: assert property (v_r |-> port_irq_o == |$past(pin_irq_flag_o & pin_irq_enable_i))
    else $error("irq bad");
  a_ce_hold: assert property (!$past(ce_i) && !$past(sys_rst_i) |-> $stable(pad_out_o))
    else $error("freeze bad");
endmodule // mux_props
bind port_function_mux mux_props mux_props_inst (.*);

// *** verif/board_model.sv ***
// board pins and timer outputs facing the port
// assumes pins wired straight to the port pads
`timescale 1ns/1ps
module board_model (
  input  wire       clk_i,
  input  wire [7:0] pad_out_i,
  input  wire [7:0] pad_oe_n_i,
  input  wire [7:0] ext_i,
  output wire [7:0] pad_o,
  output reg  [2:0] cmp_o,
  output reg        subsystem_peripheral_clock_o
);
  initial begin cmp_o = 3'h0; subsystem_peripheral_clock_o = 1'b0; end
  // compare outputs walk all patterns so each mux leg sees both levels
  always @(posedge clk_i) begin
    cmp_o <= cmp_o + 3'h1;
    subsystem_peripheral_clock_o <= ~subsystem_peripheral_clock_o;
  end
  assign pad_o = (pad_out_i & ~pad_oe_n_i) | (ext_i & pad_oe_n_i);
endmodule // board_model

// *** verif/tb_top.sv ***
// self-checking bench for the port function mux
// assumes inputs change on falling clk_i edges
`timescale 1ns/1ps
module tb_top;
  reg        clk_i = 1'b0, sys_rst_i = 1'b1;
  reg  [7:0] sel = 8'h00, dir = 8'h00, dout = 8'h00, ien = 8'h00, ies = 8'h00;
  reg  [7:0] clr = 8'h00, set = 8'h00, ext = 8'h00;
  reg        ce = 1'b1;
  wire [7:0] pad, pout, poe_n, pin, flg;
  wire [2:0] cmp;
  wire       subsystem_peripheral_clock, irq, tclk, c0, c1, c2;
  integer    n_errors = 0, n_checks = 0, cyc = 0;
  always #2 clk_i = ~clk_i;
  port_function_mux port_function_mux_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .pin_function_select_i(sel), .pin_direction_bit_i(dir), .pin_output_bit_i(dout),
    .pin_irq_enable_i(ien), .pin_irq_edge_select_i(ies), .pin_irq_flag_clr_i(clr),
    .pin_irq_flag_set_i(set), .timer_compare_out_zero_i(cmp[0]),
    .timer_compare_out_one_i(cmp[1]), .timer_compare_out_two_i(cmp[2]),
    .subsystem_peripheral_clock_i(subsystem_peripheral_clock), .pad_in_i(pad), .pad_out_o(pout),
    .pad_oe_n_o(poe_n), .pin_input_bit_o(pin), .pin_irq_flag_o(flg), .port_irq_o(irq),
    .timer_external_clock_in_o(tclk), .timer_capture_in_zero_alt_a_o(c0),
    .timer_capture_in_one_alt_a_o(c1), .timer_capture_in_two_alt_a_o(c2));
  board_model board_model_inst (.clk_i(clk_i), .pad_out_i(pout), .pad_oe_n_i(poe_n),
    .ext_i(ext), .pad_o(pad), .cmp_o(cmp), .subsystem_peripheral_clock_o(subsystem_peripheral_clock));
  task chk(input string name, input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task tick(input integer n); begin repeat (n) @(negedge clk_i); end endtask
  task setc(input [7:0] s, input [7:0] d, input [7:0] o);
    begin sel = s; dir = d; dout = o; tick(3); end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ==========================
  // hang guard, far above the sequence length
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin n_errors = n_errors + 1; test_done; end
  end
  initial begin
    tick(16);
    sys_rst_i = 1'b0;
    chk("oe_n", poe_n, 8'hFF);
    chk("out", pout, 8'h00);
    setc(8'hFF, 8'hA5, 8'h00);
    chk("oe_n", poe_n, 8'h5A);
    chk("out0", {7'h00, pout[0]}, 8'h00);
    setc(8'hFF, 8'h00, 8'h00);
    // driven compare toggles may have left flags behind
    clr = 8'hFF;
    tick(1);
    clr = 8'h00;
    chk("flag", flg, 8'h00);
    ext = 8'h0F;
    tick(4);
    chk("in", pin, 8'h0F);
    chk("cap", {4'h0, c2, c1, c0, tclk}, 8'h0F);
    chk("flag", flg, 8'h0F);
    chk("irq", {7'h00, irq}, 8'h00);
    ien = 8'h01;
    tick(2);
    chk("irq", {7'h00, irq}, 8'h01);
    clr = 8'h08;
    tick(1);
    clr = 8'hFF & 8'h00;
    tick(2);
    chk("flag", flg, 8'h07);
    clr = 8'hFF;
    tick(1);
    clr = 8'h00;
    ies = 8'hFF;
    ext = 8'h00;
    tick(5);
    chk("flag", flg, 8'h0F);
    clr = 8'hFF;
    tick(1);
    clr = 8'h00;
    set = 8'h80;
    tick(1);
    set = 8'h00;
    tick(2);
    chk("flag", flg, 8'h80);
    chk("irq", {7'h00, irq}, 8'h00);
    setc(8'h00, 8'hFF, 8'h96);
    chk("out", pout, 8'h96);
    chk("cap", {4'h0, c2, c1, c0, tclk}, 8'h00);
    tick(2);
    chk("in", pin, 8'h96);
    ce = 1'b0;
    dout = 8'h69;
    tick(3);
    chk("frozen", pout, 8'h96);
    ce = 1'b1;
    tick(1);
    chk("out", pout, 8'h69);
    test_done;
  end
endmodule // tb_top
